// ===== monitor_status_config_regs.sv
/*
 * Status/configuration and DAC configuration register bank of an
 * analog monitor. Assumes register accesses arrive already decoded
 * from the serial port on core_clk, and that the ADC sequencer and
 * DAC latches sit outside and obey the strobes given here.
 */
`timescale 1ns/1ns
module monitor_status_config_regs #(
    parameter int PULSE_CYCLES = regbank_pkg::PULSE_CYCLES,
    parameter int DAC_COUNT = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hw_reset_n_pin,
    input wire logic sw_reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_sel,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic adc_data_rd,
    input wire logic chan_done,
    input wire logic [3:0] chan_addr,
    input wire logic convert_trigger_pin,
    input wire logic external_dac_load_strobe,
    input wire logic internal_dac_load,
    input wire logic [DAC_COUNT-1:0] dac_data_wr,
    input wire logic spi_shift_en,
    input wire logic spi_sdi,
    output logic result_ready_pin_n,
    output logic adc_start,
    output logic adc_auto_mode,
    output logic [3:0] starting_address,
    output logic [3:0] ending_address,
    output logic reference_select,
    output logic reference_gain,
    output logic ref_pin_connect,
    output logic isrc_reference_select,
    output logic isrc_reference_gain,
    output logic [15:0] power_enable,
    output logic [DAC_COUNT-1:0] synchronous_load_enable,
    output logic [DAC_COUNT-1:0] output_gain_select,
    output logic [DAC_COUNT-1:0] dac_latch_load,
    output logic [15:0] dac_shift_word
);
    // ==========================================================
    // Declarations
    logic hw_q1_reg;
    logic hw_q2_reg;
    logic cnv_q1_reg;
    logic cnv_q2_reg;
    logic cnv_q3_reg;
    logic ld_q1_reg;
    logic ld_q2_reg;
    logic ld_q3_reg;
    logic any_rst;
    logic wr_status;
    logic wr_ctrl;
    logic trig_edge;
    logic ld_edge;
    logic start_next;
    logic end_hit;
    logic done_clear;
    logic rst_seen_reg;
    logic done_reg;
    logic refsel_reg;
    logic refgain_reg;
    logic trig_reg;
    logic ref_connect_reg;
    logic auto_reg;
    logic start_reg;
    logic [3:0] sa_reg;
    logic [3:0] ea_reg;
    logic [15:0] power_reg;
    logic [15:0] dac_cfg_reg;
    logic [15:0] rdata_reg;
    logic [15:0] shift_reg;
    logic [DAC_COUNT-1:0] load_reg;
    logic [15:0] status_view;

    ready_if rdy ();

    // ==========================================================
    // Synchronisers for pins; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hw_q1_reg <= 1'b1;
            hw_q2_reg <= 1'b1;
        end else begin
            hw_q1_reg <= hw_reset_n_pin;
            hw_q2_reg <= hw_q1_reg;
        end
    end

    // Trigger pin, with a third stage for the rising edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnv_q1_reg <= 1'b0;
            cnv_q2_reg <= 1'b0;
            cnv_q3_reg <= 1'b0;
        end else begin
            cnv_q1_reg <= convert_trigger_pin;
            cnv_q2_reg <= cnv_q1_reg;
            cnv_q3_reg <= cnv_q2_reg;
        end
    end

    // Load strobe pin; held low by the host at power-up so no
    // spurious edge follows reset release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ld_q1_reg <= 1'b0;
            ld_q2_reg <= 1'b0;
            ld_q3_reg <= 1'b0;
        end else begin
            ld_q1_reg <= external_dac_load_strobe;
            ld_q2_reg <= ld_q1_reg;
            ld_q3_reg <= ld_q2_reg;
        end
    end

    // ==========================================================
    // Decode: power-on, pin and software resets act alike
    assign any_rst = rst || !hw_q2_reg || sw_reset;
    assign wr_status = reg_wr && reg_sel == regbank_pkg::SEL_STATUS;
    assign wr_ctrl = reg_wr && reg_sel == regbank_pkg::SEL_ADC_CTRL;
    assign trig_edge = cnv_q2_reg && !cnv_q3_reg;
    assign ld_edge = ld_q2_reg && !ld_q3_reg;
    // Pin edge counts only in external mode, write only otherwise
    assign start_next = trig_reg ? trig_edge : wr_ctrl;
    assign end_hit = chan_done && chan_addr == ea_reg;
    assign done_clear = adc_data_rd || start_next ||
        (wr_status && !reg_wdata[regbank_pkg::DONE_BIT]);

    // ==========================================================
    // Reset-complete flag: reset sets, only a zero write clears
    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            rst_seen_reg <= 1'b1;
        end else if (wr_status && !reg_wdata[regbank_pkg::RST_SEEN_BIT]) begin
            rst_seen_reg <= 1'b0;
        end
    end

    // Conversion-done flag; held clear in auto mode, else a completing set wins over a clear
    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            done_reg <= 1'b0;
        end else if (auto_reg) begin
            done_reg <= 1'b0;
        end else if (end_hit) begin
            done_reg <= 1'b1;
        end else if (done_clear) begin
            done_reg <= 1'b0;
        end
    end

    // Reference and trigger configuration; other bits dropped
    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            refsel_reg <= 1'b0;
            refgain_reg <= 1'b0;
            trig_reg <= 1'b0;
            ref_connect_reg <= 1'b1;
        end else if (wr_status) begin
            refsel_reg <= reg_wdata[regbank_pkg::REFSEL_BIT];
            refgain_reg <= reg_wdata[regbank_pkg::REFGAIN_BIT];
            trig_reg <= reg_wdata[regbank_pkg::TRIG_BIT];
            ref_connect_reg <= !reg_wdata[regbank_pkg::REFSEL_BIT];
        end
    end

    // ==========================================================
    // Conversion control; auto mode cannot coexist with the pin
    // trigger, so enabling the pin drops back to direct mode
    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            auto_reg <= regbank_pkg::ADC_CTRL_RST[regbank_pkg::AUTO_BIT];
            sa_reg <= regbank_pkg::ADC_CTRL_RST[regbank_pkg::SA_LSB +: 4];
            ea_reg <= regbank_pkg::ADC_CTRL_RST[regbank_pkg::EA_LSB +: 4];
        end else if (wr_status && reg_wdata[regbank_pkg::TRIG_BIT]) begin
            auto_reg <= 1'b0;
        end else if (wr_ctrl) begin
            auto_reg <= reg_wdata[regbank_pkg::AUTO_BIT] && !trig_reg;
            sa_reg <= reg_wdata[regbank_pkg::SA_LSB +: 4];
            ea_reg <= reg_wdata[regbank_pkg::EA_LSB +: 4];
        end
    end

    // One-cycle start strobe to the sequencer
    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start_next;
        end
    end

    // ==========================================================
    // Power-down control; zero keeps every block powered down
    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            power_reg <= regbank_pkg::POWER_RST;
        end else if (reg_wr && reg_sel == regbank_pkg::SEL_POWER) begin
            power_reg <= reg_wdata;
        end
    end

    // DAC configuration: load enables high byte, gains low byte
    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            dac_cfg_reg <= regbank_pkg::DAC_CFG_RST;
        end else if (reg_wr && reg_sel == regbank_pkg::SEL_DAC_CFG) begin
            dac_cfg_reg <= reg_wdata;
        end
    end

    // ==========================================================
    // Latch load strobes per DAC: strobe-gated or immediate
    generate
        for (genvar i = 0; i < DAC_COUNT; i++) begin : g_load
            always_ff @(posedge core_clk) begin
                if (any_rst) begin
                    load_reg[i] <= 1'b0;
                end else if (dac_cfg_reg[8 + i]) begin
                    load_reg[i] <= ld_edge || internal_dac_load;
                end else begin
                    load_reg[i] <= dac_data_wr[i];
                end
            end
        end
    endgenerate

    // Serial input shift register; deliberately without reset so
    // a word in flight survives any reset, hence select stays idle
    always_ff @(posedge core_clk) begin
        if (spi_shift_en) begin
            shift_reg <= {shift_reg[14:0], spi_sdi};
        end
    end

    // ==========================================================
    // Read data; unused status positions and bit 12 of the status view always zero
    always_comb begin
        status_view = 16'h0000;
        status_view[regbank_pkg::RST_SEEN_BIT] = rst_seen_reg;
        status_view[regbank_pkg::DONE_BIT] = done_reg;
        status_view[regbank_pkg::ZERO_BIT] = 1'b0;
        status_view[regbank_pkg::REFSEL_BIT] = refsel_reg;
        status_view[regbank_pkg::REFGAIN_BIT] = refgain_reg;
        status_view[regbank_pkg::TRIG_BIT] = trig_reg;
    end

    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            rdata_reg <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_sel)
                regbank_pkg::SEL_STATUS: rdata_reg <= status_view;
                regbank_pkg::SEL_DAC_CFG: rdata_reg <= dac_cfg_reg;
                regbank_pkg::SEL_ADC_CTRL: begin
                    rdata_reg <= {auto_reg, 3'h0, sa_reg, ea_reg, 4'h0};
                end
                regbank_pkg::SEL_POWER: rdata_reg <= power_reg;
                default: rdata_reg <= 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // Result-ready pin driver
    assign rdy.clear = any_rst;
    assign rdy.auto_mode = auto_reg;
    assign rdy.flag = done_reg;
    assign rdy.end_pulse = end_hit && auto_reg;

    ready_pin_driver #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_ready (
        .core_clk(core_clk),
        .rdy(rdy.drv)
    );

    // ==========================================================
    // Outputs; current source shares the reference flops
    assign reg_rdata = rdata_reg;
    assign result_ready_pin_n = rdy.pin_n;
    assign adc_start = start_reg;
    assign adc_auto_mode = auto_reg;
    assign starting_address = sa_reg;
    assign ending_address = ea_reg;
    assign reference_select = refsel_reg;
    assign reference_gain = refgain_reg;
    assign ref_pin_connect = ref_connect_reg;
    assign isrc_reference_select = refsel_reg;
    assign isrc_reference_gain = refgain_reg;
    assign power_enable = power_reg;
    assign synchronous_load_enable = dac_cfg_reg[8 +: DAC_COUNT];
    assign output_gain_select = dac_cfg_reg[0 +: DAC_COUNT];
    assign dac_latch_load = load_reg;
    assign dac_shift_word = shift_reg;

    // ==========================================================
    // Checks
    property p_soft_reset;
        @(posedge core_clk) disable iff (rst)
        sw_reset |=> rst_seen_reg && !done_reg && !refsel_reg && !refgain_reg && !trig_reg
            && power_reg == regbank_pkg::POWER_RST;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset left a field set");

    property p_seen_one_write;
        @(posedge core_clk) disable iff (rst)
        (wr_status && reg_wdata[regbank_pkg::RST_SEEN_BIT] && !any_rst)
            |=> rst_seen_reg == $past(rst_seen_reg);
    endproperty
    a_seen_one_write: assert property (p_seen_one_write)
        else $error("reset-complete changed by a one write");

    property p_bit12_zero;
        @(posedge core_clk) disable iff (rst)
        reg_rd |=> reg_rdata[regbank_pkg::ZERO_BIT] == 1'b0 &&
            (reg_sel != regbank_pkg::SEL_STATUS || reg_rdata[4:0] == 5'h00);
    endproperty
    a_bit12_zero: assert property (p_bit12_zero)
        else $error("reserved status bit read nonzero");

    property p_auto_no_done;
        @(posedge core_clk) disable iff (rst)
        auto_reg |=> !done_reg || !$past(auto_reg);
    endproperty
    a_auto_no_done: assert property (p_auto_no_done)
        else $error("done flag set in auto mode");

    property p_read_clears;
        @(posedge core_clk) disable iff (rst)
        (adc_data_rd && !end_hit) |=> !done_reg;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("data read did not clear done");

    property p_ext_write_no_start;
        @(posedge core_clk) disable iff (any_rst)
        (trig_reg && wr_ctrl && !trig_edge) |=> !adc_start;
    endproperty
    a_ext_write_no_start: assert property (p_ext_write_no_start)
        else $error("control write started in external mode");

    property p_int_write_start;
        @(posedge core_clk) disable iff (any_rst)
        (!trig_reg && wr_ctrl) |=> adc_start ##1 !adc_start;
    endproperty
    a_int_write_start: assert property (p_int_write_start)
        else $error("control write did not start once");

    property p_immediate_load;
        @(posedge core_clk) disable iff (any_rst)
        (!dac_cfg_reg[8] && dac_data_wr[0]) |=> dac_latch_load[0];
    endproperty
    a_immediate_load: assert property (p_immediate_load)
        else $error("immediate DAC update missing");

    c_ext_start: cover property (@(posedge core_clk) trig_reg && trig_edge);
    c_done_set: cover property (@(posedge core_clk) !auto_reg && end_hit);
    c_strobe_load: cover property (@(posedge core_clk) ld_edge && dac_cfg_reg[8]);
endmodule

// ===== regbank_pkg.sv
/*
 * Constants for the status/configuration register bank: register
 * selects, field positions, values after reset and pulse timing.
 * Assumes a single 125 MHz core clock.
 */
package regbank_pkg;
    // ==========================================================
    // Register selects on the decoded serial-port access
    localparam logic [1:0] SEL_STATUS = 2'h0;
    localparam logic [1:0] SEL_DAC_CFG = 2'h1;
    localparam logic [1:0] SEL_ADC_CTRL = 2'h2;
    localparam logic [1:0] SEL_POWER = 2'h3;

    // ==========================================================
    // Status/configuration field positions
    localparam int RST_SEEN_BIT = 14;
    localparam int DONE_BIT = 13;
    localparam int ZERO_BIT = 12;
    localparam int REFSEL_BIT = 7;
    localparam int REFGAIN_BIT = 6;
    localparam int TRIG_BIT = 5;

    // ==========================================================
    // ADC control field positions
    localparam int AUTO_BIT = 15;
    localparam int SA_LSB = 8;
    localparam int EA_LSB = 4;

    // ==========================================================
    // Values after reset
    localparam logic [15:0] DAC_CFG_RST = 16'h0000;
    localparam logic [15:0] ADC_CTRL_RST = 16'h0000;
    localparam logic [15:0] POWER_RST = 16'h0000;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PULSE_NS = 2000;
    localparam int PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;
endpackage

// ===== ready_if.sv
/*
 * Carrier between the register bank and the result-ready pin driver.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/1ns
interface ready_if;
    logic clear;
    logic auto_mode;
    logic flag;
    logic end_pulse;
    logic pin_n;
    modport ctl (output clear, output auto_mode, output flag, output end_pulse, input pin_n);
    modport drv (input clear, input auto_mode, input flag, input end_pulse, output pin_n);
endinterface

// ===== ready_pin_driver.sv
/*
 * Drives the active-low result-ready pin: a level in direct mode,
 * a timed low pulse in auto mode. Assumes clear is synchronous.
 */
`timescale 1ns/1ns
module ready_pin_driver #(
    parameter int PULSE_CYCLES = regbank_pkg::PULSE_CYCLES
) (
    input wire logic core_clk,
    ready_if.drv rdy
);
    localparam int CW = $clog2(PULSE_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(PULSE_CYCLES - 1);

    logic [CW-1:0] cnt_reg;
    logic pin_n_reg;

    // ==========================================================
    // Pulse length counter, restarted by each end-of-set event
    always_ff @(posedge core_clk) begin
        if (rdy.clear || !rdy.auto_mode) begin
            cnt_reg <= '0;
        end else if (rdy.end_pulse) begin
            cnt_reg <= LOAD;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Pin level; high while in reset so the host sees no data
    always_ff @(posedge core_clk) begin
        if (rdy.clear) begin
            pin_n_reg <= 1'b1;
        end else if (rdy.auto_mode) begin
            pin_n_reg <= !(rdy.end_pulse || cnt_reg != '0);
        end else begin
            pin_n_reg <= !rdy.flag;
        end
    end

    assign rdy.pin_n = pin_n_reg;

    // ==========================================================
    // Checks
    property p_direct_level;
        @(posedge core_clk) disable iff (rdy.clear)
        (!rdy.auto_mode && rdy.flag) |=> (rdy.pin_n == 1'b0);
    endproperty
    a_direct_level: assert property (p_direct_level)
        else $error("result-ready not low with done flag");

    property p_auto_pulse;
        @(posedge core_clk) disable iff (rdy.clear)
        (rdy.auto_mode && rdy.end_pulse) ##1 rdy.auto_mode [*8]
            |-> rdy.pin_n == 1'b0 && cnt_reg != '0;
    endproperty
    a_auto_pulse: assert property (p_auto_pulse)
        else $error("auto pulse ended early");

    c_auto_pulse: cover property (@(posedge core_clk)
        rdy.auto_mode && rdy.end_pulse);
endmodule

// ===== host_model.sv
/*
 * Host controller model on the decoded serial-port side: register
 * writes and reads, serial shifting, and the idle pin levels.
 * Assumes core_clk comes from the bench; drives on the falling edge.
 */
`timescale 1ns/1ns
module host_model (
    input wire logic core_clk,
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [1:0] reg_sel,
    output logic [15:0] reg_wdata,
    output logic external_dac_load_strobe,
    output logic spi_shift_en,
    output logic spi_sdi
);
    // ====================
    // Idle from power-up: select off, load strobe held low
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_sel = 2'h0;
        reg_wdata = 16'h0000;
        external_dac_load_strobe = 1'b0;
        spi_shift_en = 1'b0;
        spi_sdi = 1'b0;
    end

    // One-cycle write; data shows garbage once released
    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        @(negedge core_clk);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // Read data is registered, so sample one cycle after the strobe
    task automatic rd(input logic [1:0] s, output logic [15:0] d);
        @(negedge core_clk);
        reg_sel = s;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // Sixteen serial bits, most significant first
    task automatic shift(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(negedge core_clk);
            spi_shift_en = 1'b1;
            spi_sdi = w[i];
        end
        @(negedge core_clk);
        spi_shift_en = 1'b0;
        spi_sdi = ~spi_sdi;
    endtask
endmodule

// ===== monitor_status_config_regs_tb.sv
/*
 * Bench for the status/configuration register bank. The host model
 * makes register accesses; conversion events and resets come from here.
 * Assumes the design files and host_model.sv are compiled first.
 */
`timescale 1ns/1ns
module monitor_status_config_regs_tb;
    logic core_clk = 1'b0, rst = 1'b1, hw_reset_n_pin = 1'b1, sw_reset = 1'b0;
    logic chan_done = 1'b0, convert_trigger_pin = 1'b0, internal_dac_load = 1'b0;
    logic adc_data_rd = 1'b0;
    logic [3:0] chan_addr = 4'h0;
    logic [7:0] dac_data_wr = 8'h00;
    logic reg_wr, reg_rd, spi_shift_en, spi_sdi, external_dac_load_strobe;
    logic [1:0] reg_sel;
    logic [15:0] reg_wdata, reg_rdata, power_enable, dac_shift_word, rv;
    logic result_ready_pin_n, adc_start, adc_auto_mode, reference_select, reference_gain;
    logic ref_pin_connect, isrc_reference_select, isrc_reference_gain;
    logic [3:0] starting_address, ending_address;
    logic [7:0] synchronous_load_enable, output_gain_select, dac_latch_load;
    int miscompares = 0, checks_done = 0, st, lo;

    // Short pulse count keeps the auto-mode test quick
    monitor_status_config_regs #(.PULSE_CYCLES(10), .DAC_COUNT(8)) dut (
        .core_clk(core_clk), .rst(rst), .hw_reset_n_pin(hw_reset_n_pin),
        .sw_reset(sw_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_data_rd(adc_data_rd),
        .chan_done(chan_done), .chan_addr(chan_addr),
        .convert_trigger_pin(convert_trigger_pin),
        .external_dac_load_strobe(external_dac_load_strobe),
        .internal_dac_load(internal_dac_load), .dac_data_wr(dac_data_wr),
        .spi_shift_en(spi_shift_en), .spi_sdi(spi_sdi),
        .result_ready_pin_n(result_ready_pin_n), .adc_start(adc_start),
        .adc_auto_mode(adc_auto_mode), .starting_address(starting_address),
        .ending_address(ending_address), .reference_select(reference_select),
        .reference_gain(reference_gain), .ref_pin_connect(ref_pin_connect),
        .isrc_reference_select(isrc_reference_select),
        .isrc_reference_gain(isrc_reference_gain), .power_enable(power_enable),
        .synchronous_load_enable(synchronous_load_enable),
        .output_gain_select(output_gain_select), .dac_latch_load(dac_latch_load),
        .dac_shift_word(dac_shift_word)
    );

    host_model host (
        .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_sel(reg_sel), .reg_wdata(reg_wdata),
        .external_dac_load_strobe(external_dac_load_strobe),
        .spi_shift_en(spi_shift_en), .spi_sdi(spi_sdi)
    );

    always #4 core_clk = ~core_clk;

    // ====================
    // Helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    // Counts start pulses and low pin cycles over n cycles
    task automatic watch(input int n, output int s, output int l);
        s = 0;
        l = 0;
        repeat (n) begin
            @(negedge core_clk);
            s += int'(adc_start === 1'b1);
            l += int'(result_ready_pin_n === 1'b0);
        end
    endtask

    task automatic done_evt(input logic [3:0] a);
        @(negedge core_clk);
        chan_addr = a;
        chan_done = 1'b1;
        @(negedge core_clk);
        chan_done = 1'b0;
    endtask

    task automatic results;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the roughly two hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        results();
    end

    // ====================
    // Test sequence
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        host.rd(2'h0, rv);
        chk(rv, 16'h4000);
        chk({15'h0000, result_ready_pin_n}, 16'h0001);
        // Ones everywhere: bit 12, don't-cares and flags must not take them
        host.wr(2'h0, 16'hFFFF);
        host.rd(2'h0, rv);
        chk(rv, 16'h40E0);
        chk(16'({reference_select, reference_gain, ref_pin_connect,
            isrc_reference_select, isrc_reference_gain}), 16'h001B);
        host.wr(2'h0, 16'h0000);
        host.rd(2'h0, rv);
        chk(rv, 16'h0000);
        chk({15'h0000, ref_pin_connect}, 16'h0001);
        $display("test status bits done");
        // Trigger pin ignored under internal trigger
        convert_trigger_pin = 1'b1;
        watch(6, st, lo);
        convert_trigger_pin = 1'b0;
        chk(16'(st), 16'h0000);
        host.wr(2'h2, 16'h0070);
        chk({15'h0000, adc_start}, 16'h0001);
        chk({8'h00, starting_address, ending_address}, 16'h0007);
        // Direct mode: three ways of clearing the done flag
        for (int k = 0; k < 3; k++) begin
            done_evt(4'h6);
            watch(3, st, lo);
            chk(16'(lo), 16'h0000);
            done_evt(4'h7);
            watch(3, st, lo);
            chk({15'h0000, result_ready_pin_n}, 16'h0000);
            host.rd(2'h0, rv);
            chk(rv, 16'h2000);
            case (k)
                0: begin
                    adc_data_rd = 1'b1;
                    @(negedge core_clk);
                    adc_data_rd = 1'b0;
                end
                1: host.wr(2'h2, 16'h0070);
                default: host.wr(2'h0, 16'h0000);
            endcase
            watch(3, st, lo);
            chk({15'h0000, result_ready_pin_n}, 16'h0001);
        end
        $display("test direct mode done");
        // Auto mode: timed low pulse, flag stays clear
        host.wr(2'h2, 16'h8070);
        chk({14'h0000, adc_auto_mode, adc_start}, 16'h0003);
        done_evt(4'h7);
        // Pin already low for one cycle when the event task returns
        chk({15'h0000, result_ready_pin_n}, 16'h0000);
        watch(20, st, lo);
        chk(16'(lo), 16'h0009);
        host.rd(2'h0, rv);
        chk(rv, 16'h0000);
        $display("test auto mode done");
        // External trigger: write only selects, pin edge starts
        host.wr(2'h0, 16'h0020);
        host.wr(2'h2, 16'h8070);
        chk({15'h0000, adc_start}, 16'h0000);
        host.rd(2'h2, rv);
        chk(rv, 16'h0070);
        chk({15'h0000, adc_auto_mode}, 16'h0000);
        convert_trigger_pin = 1'b1;
        watch(6, st, lo);
        convert_trigger_pin = 1'b0;
        chk(16'(st), 16'h0001);
        $display("test external trigger done");
        // DAC loads: DAC0 on internal load only, DAC1 on data write
        host.wr(2'h1, 16'h0102);
        host.rd(2'h1, rv);
        chk(rv, 16'h0102);
        chk({synchronous_load_enable, output_gain_select}, 16'h0102);
        dac_data_wr = 8'h03;
        @(negedge core_clk);
        dac_data_wr = 8'h00;
        chk({8'h00, dac_latch_load}, 16'h0002);
        internal_dac_load = 1'b1;
        @(negedge core_clk);
        internal_dac_load = 1'b0;
        chk({8'h00, dac_latch_load}, 16'h0001);
        $display("test dac config done");
        // Software then hardware reset; shift word must survive both
        host.shift(16'hA5A5);
        for (int k = 0; k < 2; k++) begin
            host.wr(2'h3, 16'hFFFF);
            host.wr(2'h0, 16'h00E0);
            chk(power_enable, 16'hFFFF);
            @(negedge core_clk);
            sw_reset = (k == 0);
            hw_reset_n_pin = (k == 0);
            repeat (4) @(negedge core_clk);
            sw_reset = 1'b0;
            hw_reset_n_pin = 1'b1;
            repeat (4) @(negedge core_clk);
            chk(dac_shift_word, 16'hA5A5);
            chk(power_enable, 16'h0000);
            host.rd(2'h0, rv);
            chk(rv, 16'h4000);
            host.rd(2'h1, rv);
            chk(rv, 16'h0000);
        end
        $display("test resets done");
        results();
    end
endmodule
